// [logic/pdcs_regs.svh]
// Register offsets, field positions and timing counts for power-down control
`ifndef PDCS_REGS_SVH
`define PDCS_REGS_SVH
`define SBY_CTRL_OFS   12'h000
`define LPW_CTRL_OFS   12'h004
`define SBY_STANDBY_SELECT_FLAG_BIT   7
`define SBY_STS_LSB    4
`define SBY_RSV_BIT    3
`define SBY_SCK_LSB    0
`define LPW_DIRECT_TRANSFER_FLAG_BIT   7
`define LPW_LOW_SPEED_FLAG_BIT   6
`define DIV_SEL_MAX    3'h5
`define STS_SEL_MAX    3'h5
`define STAB_BASE      8192
`endif

// [logic/pdcs_pkg.sv]
// Types shared by the power-down clock select block
package pdcs_pkg;
  typedef enum logic [2:0] {
    MODE_ACTIVE   = 3'b000,
    MODE_SLEEP    = 3'b001,
    MODE_STANDBY  = 3'b010,
    MODE_WATCH    = 3'b011,
    MODE_SUBACT   = 3'b100,
    MODE_SUBSLEEP = 3'b101,
    MODE_OSCWAIT  = 3'b110
  } mode_t;
endpackage

// [logic/power_down_clock_select.sv]
// Power-down clock select, stabilization wait and mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pdcs_regs.svh"

// Operation
// - Divider select clocks bus master, 000 full
// - Divider select resets to zero
// - Bit above divider reads zero, ignores writes
// - Wait select picks 8192 to 262144 states
// - Direct-transfer flag sampled at sleep
// - Direct-transfer flag resets zero, read/write
// - Active, flag zero: sleep, standby, watch
// - Active, flag one: subactive, sleep, standby
// - Subactive, flag zero: subsleep or watch
// - Subactive, flag one: high-speed, watch or subsleep
// - Standby select zero gives sleep mode, or subsleep from subactive
// - Wait applies when leaving standby, watch, subactive
// - Low-speed flag picks watch exit mode
module power_down_clock_select
  import pdcs_pkg::*;
#(
  parameter int STAB_BASE = `STAB_BASE
) (
  input  wire logic        pclk,          // System clock
  input  wire logic        presetn,       // Async reset, low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB write
  input  wire logic [11:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  input  wire logic        sleep_exec,    // Sleep instruction pulse
  input  wire logic        wake_req,      // Cancel request
  output logic             bm_clk_en,     // Bus master clock enable
  output logic             cpu_run,       // Core clocks released
  output logic             main_osc_on,   // Main oscillator on
  output logic             sub_clk_sel,   // Core on subclock
  output logic [2:0]       mode           // Current mode
);

  logic        standby_select_flag_q, standby_select_flag_d;
  logic [2:0]  sts_q, sts_d;
  logic [2:0]  sck_q, sck_d;
  logic        direct_transfer_flag_q, direct_transfer_flag_d;
  logic        low_speed_flag_q, low_speed_flag_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [4:0]  div_cnt_q, div_cnt_d;
  logic [2:0]  div_act_q, div_act_d;
  logic        bm_en_q, bm_en_d;
  mode_t       mode_q, mode_d;
  logic [18:0] stab_cnt_q, stab_cnt_d;
  logic [18:0] stab_tgt;
  logic        tick;
  logic        sby_hit, lpw_hit, wr_go;

  function automatic logic [4:0] div_mask(input logic [2:0] sel);
    div_mask = 5'((6'h01 << sel) - 6'h01);
  endfunction

  function automatic logic [18:0] wait_len(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > `STS_SEL_MAX) ? `STS_SEL_MAX : sel;
    wait_len = 19'(STAB_BASE) << s;
  endfunction

  assign sby_hit = (paddr == `SBY_CTRL_OFS);
  assign lpw_hit = (paddr == `LPW_CTRL_OFS);
  assign wr_go   = psel && penable && pready_q && pwrite;

  // Register file and bus answer
  always_comb begin
    standby_select_flag_d    = standby_select_flag_q;
    sts_d     = sts_q;
    sck_d     = sck_q;
    direct_transfer_flag_d    = direct_transfer_flag_q;
    low_speed_flag_d    = low_speed_flag_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    pready_d  = psel && penable && !pready_q;
    if (pready_d) begin
      pslverr_d = !(sby_hit || lpw_hit);
      prdata_d  = 32'h0000_0000;
      if (sby_hit) begin
        prdata_d[`SBY_STANDBY_SELECT_FLAG_BIT]          = standby_select_flag_q;
        prdata_d[`SBY_STS_LSB +: 3]      = sts_q;
        prdata_d[`SBY_RSV_BIT]           = 1'b0;
        prdata_d[`SBY_SCK_LSB +: 3]      = sck_q;
      end else if (lpw_hit) begin
        prdata_d[`LPW_DIRECT_TRANSFER_FLAG_BIT]          = direct_transfer_flag_q;
        prdata_d[`LPW_LOW_SPEED_FLAG_BIT]          = low_speed_flag_q;
      end
    end
    if (wr_go && sby_hit) begin
      standby_select_flag_d = pwdata[`SBY_STANDBY_SELECT_FLAG_BIT];
      sts_d  = pwdata[`SBY_STS_LSB +: 3];
      sck_d  = pwdata[`SBY_SCK_LSB +: 3];
    end
    if (wr_go && lpw_hit) begin
      direct_transfer_flag_d = pwdata[`LPW_DIRECT_TRANSFER_FLAG_BIT];
      low_speed_flag_d = pwdata[`LPW_LOW_SPEED_FLAG_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_select_flag_q    <= 1'b0;
      sts_q     <= 3'h0;
      sck_q     <= 3'h0;
      direct_transfer_flag_q    <= 1'b0;
      low_speed_flag_q    <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      standby_select_flag_q    <= standby_select_flag_d;
      sts_q     <= sts_d;
      sck_q     <= sck_d;
      direct_transfer_flag_q    <= direct_transfer_flag_d;
      low_speed_flag_q    <= low_speed_flag_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Bus master divider; new ratio only at a period boundary
  assign tick = (div_cnt_q == div_mask(div_act_q));

  always_comb begin
    div_cnt_d = div_cnt_q + 5'h01;
    div_act_d = div_act_q;
    if (tick) begin
      div_cnt_d = 5'h00;
      if (sck_q <= `DIV_SEL_MAX)
        div_act_d = sck_q;
    end
    bm_en_d = tick && (mode_q == MODE_ACTIVE) && !sleep_exec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 5'h00;
      div_act_q <= 3'h0;
      bm_en_q   <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      div_act_q <= div_act_d;
      bm_en_q   <= bm_en_d;
    end
  end

  // Mode sequencer and oscillation wait
  assign stab_tgt = wait_len(sts_q);

  always_comb begin
    mode_d     = mode_q;
    stab_cnt_d = stab_cnt_q;
    case (mode_q)
      MODE_ACTIVE: begin
        if (sleep_exec) begin
          if (!standby_select_flag_q)
            mode_d = MODE_SLEEP;
          else if (low_speed_flag_q && direct_transfer_flag_q)
            mode_d = MODE_SUBACT;
          else if (low_speed_flag_q)
            mode_d = MODE_WATCH;
          else
            mode_d = MODE_STANDBY;
        end
      end
      MODE_SUBACT: begin
        if (sleep_exec) begin
          if (!standby_select_flag_q)
            mode_d = MODE_SUBSLEEP;
          else if (direct_transfer_flag_q && !low_speed_flag_q)
            mode_d = MODE_OSCWAIT;
          else
            mode_d = MODE_WATCH;
        end
      end
      MODE_SLEEP: begin
        if (wake_req)
          mode_d = MODE_ACTIVE;
      end
      MODE_SUBSLEEP: begin
        if (wake_req)
          mode_d = MODE_SUBACT;
      end
      MODE_STANDBY: begin
        if (wake_req)
          mode_d = MODE_OSCWAIT;
      end
      MODE_WATCH: begin
        if (wake_req)
          mode_d = low_speed_flag_q ? MODE_SUBACT : MODE_OSCWAIT;
      end
      MODE_OSCWAIT: begin
        stab_cnt_d = stab_cnt_q + 19'h00001;
        if (stab_cnt_q == stab_tgt - 19'h00001)
          mode_d = MODE_ACTIVE;
      end
      default: mode_d = MODE_ACTIVE;
    endcase
    if (mode_d == MODE_OSCWAIT && mode_q != MODE_OSCWAIT)
      stab_cnt_d = 19'h00000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q     <= MODE_ACTIVE;
      stab_cnt_q <= 19'h00000;
    end else begin
      mode_q     <= mode_d;
      stab_cnt_q <= stab_cnt_d;
    end
  end

  // Output flops
  logic cpu_run_q, osc_on_q, sub_sel_q;
  logic [2:0] mode_out_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_run_q  <= 1'b1;
      osc_on_q   <= 1'b1;
      sub_sel_q  <= 1'b0;
      mode_out_q <= 3'h0;
    end else begin
      cpu_run_q  <= (mode_d == MODE_ACTIVE) || (mode_d == MODE_SUBACT);
      osc_on_q   <= (mode_d == MODE_ACTIVE) || (mode_d == MODE_SLEEP) ||
                    (mode_d == MODE_OSCWAIT);
      sub_sel_q  <= (mode_d == MODE_SUBACT);
      mode_out_q <= mode_d;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign bm_clk_en   = bm_en_q;
  assign cpu_run     = cpu_run_q;
  assign main_osc_on = osc_on_q;
  assign sub_clk_sel = sub_sel_q;
  assign mode        = mode_out_q;

  // Checks
  property p_rsv_zero;
    @(posedge pclk) disable iff (!presetn)
      (pready_d && sby_hit) |=> (prdata_q[3] == 1'b0 && prdata_q[31:8] == 0);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved bit read nonzero");

  property p_full_rate;
    @(posedge pclk) disable iff (!presetn)
      (mode_q == MODE_ACTIVE && div_act_q == 3'h0 && !sleep_exec)
        |=> bm_en_q;
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("full rate enable missing");

  property p_half_rate;
    @(posedge pclk) disable iff (!presetn)
      (bm_en_q && div_act_q == 3'h1 && sck_q == 3'h1) |=> !bm_en_q;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("divide by two broken");

  property p_act_sleep;
    @(posedge pclk) disable iff (!presetn)
      (mode_q == MODE_ACTIVE && sleep_exec && !standby_select_flag_q)
        |=> mode_q == MODE_SLEEP && !cpu_run_q;
  endproperty
  a_act_sleep: assert property (p_act_sleep)
    else $error("sleep not entered");

  property p_act_watch;
    @(posedge pclk) disable iff (!presetn)
      (mode_q == MODE_ACTIVE && sleep_exec && standby_select_flag_q && low_speed_flag_q && !direct_transfer_flag_q)
        |=> mode_q == MODE_WATCH;
  endproperty
  a_act_watch: assert property (p_act_watch)
    else $error("watch not entered");

  property p_act_direct;
    @(posedge pclk) disable iff (!presetn)
      (mode_q == MODE_ACTIVE && sleep_exec && standby_select_flag_q && low_speed_flag_q && direct_transfer_flag_q)
        |=> mode_q == MODE_SUBACT;
  endproperty
  a_act_direct: assert property (p_act_direct)
    else $error("direct subactive missed");

  property p_sub_sleep;
    @(posedge pclk) disable iff (!presetn)
      (mode_q == MODE_SUBACT && sleep_exec && !standby_select_flag_q)
        |=> mode_q == MODE_SUBSLEEP;
  endproperty
  a_sub_sleep: assert property (p_sub_sleep)
    else $error("subsleep not entered");

  property p_sub_direct;
    @(posedge pclk) disable iff (!presetn)
      (mode_q == MODE_SUBACT && sleep_exec && standby_select_flag_q && direct_transfer_flag_q && !low_speed_flag_q)
        |=> mode_q == MODE_OSCWAIT;
  endproperty
  a_sub_direct: assert property (p_sub_direct)
    else $error("direct high-speed missed");

  property p_wait_len;
    @(posedge pclk) disable iff (!presetn)
      (mode_q == MODE_OSCWAIT && stab_cnt_q < stab_tgt - 19'h00001)
        |=> mode_q == MODE_OSCWAIT;
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("wait ended early");

  property p_watch_exit;
    @(posedge pclk) disable iff (!presetn)
      (mode_q == MODE_WATCH && wake_req && !low_speed_flag_q)
        |=> mode_q == MODE_OSCWAIT ##1 !cpu_run_q;
  endproperty
  a_watch_exit: assert property (p_watch_exit)
    else $error("watch exit wrong");

endmodule
`default_nettype wire

// [test/core_model.sv]
// Core model issuing sleep instructions and wake requests
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic pclk,       // System clock
  input  wire logic cpu_run,    // Core clocks on
  output logic      sleep_exec, // Sleep pulse
  output logic      wake_req    // Cancel pulse
);
  initial begin
    sleep_exec = 1'b0;
    wake_req   = 1'b0;
  end
  // Sleep only executes while the core is clocked
  task automatic sleep1;
    while (cpu_run !== 1'b1) @(posedge pclk);
    sleep_exec <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
  endtask
  task automatic wake1;
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/tb_power_down_clock_select.sv]
// Testbench for the power-down clock select block
`timescale 1ns/1ps
`default_nettype none
module tb_power_down_clock_select;
  import pdcs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, sleep_exec, wake_req, er;
  logic        bm_clk_en, cpu_run, main_osc_on, sub_clk_sel;
  logic [2:0]  mode;
  int          err_total = 0, n_compared = 0;
  always #2.5 pclk = ~pclk;
  power_down_clock_select #(.STAB_BASE(8)) i_power_down_clock_select (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
    .wake_req(wake_req), .bm_clk_en(bm_clk_en), .cpu_run(cpu_run),
    .main_osc_on(main_osc_on), .sub_clk_sel(sub_clk_sel), .mode(mode));
  core_model i_core_model (.pclk(pclk), .cpu_run(cpu_run),
    .sleep_exec(sleep_exec), .wake_req(wake_req));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    $display("Counts: %0d compared, %0d mismatched", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Divider kept at zero before every sleep
  task automatic setr(input logic s, input logic [2:0] t,
                      input logic d, input logic l);
    apb(1'b1, 12'h000, {24'h0, s, t, 4'h0});
    apb(1'b1, 12'h004, {24'h0, d, l, 6'h0});
  endtask
  task automatic cnt_bm(input int e);
    int n;
    n = 0;
    repeat (64) begin
      @(posedge pclk);
      if (bm_clk_en === 1'b1) n++;
    end
    chk(n, e);
  endtask
  task automatic wmode(input mode_t e);
    int n;
    n = 0;
    while (mode !== e && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(mode, e);
  endtask
  task automatic t_reset;
    chk(mode, MODE_ACTIVE);
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h0);
    cnt_bm(64);
    $display("reset test done");
  endtask
  task automatic t_regs;
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    rdc(12'h000, 32'hF7);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    rdc(12'h004, 32'hC0);
    apb(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    setr(1'b0, 3'h0, 1'b0, 1'b0);
    rdc(12'h000, 32'h0);
    $display("register test done");
  endtask
  task automatic t_div;
    for (int c = 1; c <= 6; c++) begin
      apb(1'b1, 12'h000, c);
      repeat (40) @(posedge pclk);
      cnt_bm(64 >> (c > 5 ? 5 : c));
    end
    apb(1'b1, 12'h000, 32'h0);
    repeat (40) @(posedge pclk);
    $display("divider test done");
  endtask
  task automatic t_stby;
    int n;
    logic [2:0] s[3] = '{3'h0, 3'h3, 3'h7};
    i_core_model.sleep1();
    wmode(MODE_SLEEP);
    chk(cpu_run, 1'b0);
    i_core_model.wake1();
    wmode(MODE_ACTIVE);
    foreach (s[i]) begin
      setr(1'b1, s[i], 1'b0, 1'b0);
      i_core_model.sleep1();
      wmode(MODE_STANDBY);
      chk(main_osc_on, 1'b0);
      i_core_model.wake1();
      wmode(MODE_OSCWAIT);
      chk(cpu_run, 1'b0);
      n = 0;
      while (mode === MODE_OSCWAIT && n < 3000) begin
        @(posedge pclk);
        n++;
      end
      chk(n, 8 << (s[i] > 5 ? 5 : s[i]));
      chk(mode, MODE_ACTIVE);
    end
    $display("standby test done");
  endtask
  task automatic go(input logic [3:0] f, input mode_t e, input logic w);
    setr(f[3], 3'h0, f[2], f[1]);
    i_core_model.sleep1();
    wmode(e);
    if (w) i_core_model.wake1();
  endtask
  task automatic t_sub;
    go(4'hE, MODE_SUBACT, 0);
    chk(sub_clk_sel, 1'b1);
    go(4'h2, MODE_SUBSLEEP, 1);
    wmode(MODE_SUBACT);
    go(4'hA, MODE_WATCH, 1);
    wmode(MODE_SUBACT);
    go(4'hC, MODE_OSCWAIT, 0);
    wmode(MODE_ACTIVE);
    go(4'hA, MODE_WATCH, 1);
    wmode(MODE_SUBACT);
    go(4'h8, MODE_WATCH, 1);
    wmode(MODE_OSCWAIT);
    wmode(MODE_ACTIVE);
    $display("subactive test done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_div();
    t_stby();
    t_sub();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
